/* mzs_pkg.sv */
// Constants and types for the motor zone status register bank
// Contract
// - Right motor current reported in milliamperes
// - Right motor frequency reported in hertz
// - Temperature word: motor high, board low
// - Status bits 1:0 encode rotation state
// - 00 stop, 01 CCW, 10 CW, 11 free
// - Bits 5..13 fault flags; 3,4 reserved
// - Bit2 digital mode, 14 sensor, 15 unused
// - Port I/O bit 12 flags short circuit
// - Port I/O bit 14 flags over 1A
// - Neighbour code in low or high byte
// - Codes 01 clear stopped, 02 clear running
// - Codes 04 discharging, 05 blocked, 06 busy
// - Two 16-bit upstream carton tracking words
// - Cleared connections freeze neighbour and tracking words
// - Servo position is signed relative to zero
// - Servo bit 0 set when command complete
// - Servo bit 1 echoes command bit 0
// - Servo bit 2 echoes command bit 1
// - Assembly word 18 reserved for reset protection
`default_nettype none
package mzs_pkg;
  // Register offsets, module address space
  localparam logic [15:0] OFS_L_SERVO_STAT = 16'h000b;
  localparam logic [15:0] OFS_R_SERVO_STAT = 16'h0010;
  localparam logic [15:0] OFS_L_DIO_STAT = 16'h003c;
  localparam logic [15:0] OFS_L_SERVO_POS = 16'h003e;
  localparam logic [15:0] OFS_R_CURRENT = 16'h004f;
  localparam logic [15:0] OFS_R_FREQ = 16'h0050;
  localparam logic [15:0] OFS_R_TEMP = 16'h0051;
  localparam logic [15:0] OFS_R_STATUS = 16'h0052;
  localparam logic [15:0] OFS_R_DIO_STAT = 16'h0054;
  localparam logic [15:0] OFS_R_SERVO_POS = 16'h0056;
  localparam logic [15:0] OFS_UP_STATE = 16'h0086;
  localparam logic [15:0] OFS_UP_TRK1 = 16'h008b;
  localparam logic [15:0] OFS_UP_TRK2 = 16'h008c;
  localparam logic [15:0] OFS_DN_STATE = 16'h00e8;
  // Assembly word 18 (assembled address 1718) kept for reset protection
  localparam logic [15:0] ASM_RESET_PROT = 16'h06b6;
  // Motor status field positions
  localparam int STAT_ROT_LSB = 0;
  localparam int STAT_DIGITAL = 2;
  localparam int STAT_FAULT_LSB = 5;
  localparam int STAT_SENSOR_ERR = 14;
  localparam int STAT_NOT_USED = 15;
  localparam int FAULT_W = 9;
  // Port digital I/O field positions
  localparam int DIO_SHORT = 12;
  localparam int DIO_OVERCUR = 14;
  // Servo status field positions
  localparam int SRV_DONE = 0;
  localparam int SRV_ECHO0 = 1;
  localparam int SRV_ECHO1 = 2;
  // Reset value of every word
  localparam logic [15:0] WORD_RST = 16'h0000;
  // Rotation state encoding
  localparam logic [1:0] ROT_STOP = 2'h0;
  localparam logic [1:0] ROT_CCW = 2'h1;
  localparam logic [1:0] ROT_CW = 2'h2;
  localparam logic [1:0] ROT_FREE = 2'h3;
  // Neighbour zone state codes
  typedef enum logic [7:0] {
    ZONE_CLEAR_STOP = 8'h01,
    ZONE_CLEAR_RUN = 8'h02,
    ZONE_BLOCK_RUN = 8'h04,
    ZONE_BLOCK_STOP = 8'h05,
    ZONE_BUSY = 8'h06
  } mzs_zone_t;
  typedef logic [15:0] mzs_word_t;
endpackage
`default_nettype wire

/* mzs_nbr_if.sv */
// Carrier between the register bank and the neighbour capture unit
`timescale 1ns/100ps
`default_nettype none
interface mzs_nbr_if;
  import mzs_pkg::*;
  logic keep;
  logic up_wr;
  logic dn_wr;
  logic trk_wr;
  mzs_word_t up_word;
  mzs_word_t dn_word;
  mzs_word_t trk1;
  mzs_word_t trk2;
  mzs_word_t up_state;
  mzs_word_t dn_state;
  mzs_word_t up_trk1;
  mzs_word_t up_trk2;
  modport bank (output keep, up_wr, dn_wr, trk_wr, up_word, dn_word,
    trk1, trk2, input up_state, dn_state, up_trk1, up_trk2);
  modport cap (input keep, up_wr, dn_wr, trk_wr, up_word, dn_word,
    trk1, trk2, output up_state, dn_state, up_trk1, up_trk2);
endinterface
`default_nettype wire

/* mzs_nbr_capture.sv */
// Neighbour zone state and upstream tracking capture
`timescale 1ns/100ps
`default_nettype none
module mzs_nbr_capture (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  mzs_nbr_if.cap nb
);
  import mzs_pkg::*;

  // Zone code may sit in either byte; the other byte must be zero
  function automatic logic code_ok(input mzs_word_t w);
    logic [7:0] c;
    c = (w[7:0] != 8'h00) ? w[7:0] : w[15:8];
    code_ok = ((w[7:0] == 8'h00) || (w[15:8] == 8'h00)) &&
      (c == ZONE_CLEAR_STOP || c == ZONE_CLEAR_RUN ||
       c == ZONE_BLOCK_RUN || c == ZONE_BLOCK_STOP || c == ZONE_BUSY);
  endfunction

  // Upstream state capture
  // valid code, kept connection
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      nb.up_state <= WORD_RST;
    end else if (nb.keep && nb.up_wr && code_ok(nb.up_word)) begin
      nb.up_state <= nb.up_word;
    end
  end

  // Downstream state capture
  // gated neighbour update
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      nb.dn_state <= WORD_RST;
    end else if (nb.keep && nb.dn_wr && code_ok(nb.dn_word)) begin
      nb.dn_state <= nb.dn_word;
    end
  end

  // Tracking pair captured together
  // both words as one carton
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      nb.up_trk1 <= WORD_RST;
      nb.up_trk2 <= WORD_RST;
    end else if (nb.keep && nb.trk_wr) begin
      nb.up_trk1 <= nb.trk1;
      nb.up_trk2 <= nb.trk2;
    end
  end

  // Frozen words when connections are cleared
  property p_frozen;
    @(posedge sys_clk_i) disable iff (rst_i)
      !nb.keep |=> $stable(nb.up_state) && $stable(nb.dn_state) &&
        $stable(nb.up_trk1) && $stable(nb.up_trk2);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("neighbour word changed while connections cleared");

  // Stored upstream code is always a legal zone state or reset
  property p_code_legal;
    @(posedge sys_clk_i) disable iff (rst_i)
      nb.up_state != WORD_RST |-> code_ok(nb.up_state);
  endproperty
  a_code_legal: assert property (p_code_legal)
    else $error("upstream state holds an illegal code");

  c_trk: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    nb.keep && nb.trk_wr);
endmodule
`default_nettype wire

/* mzs_status_bank.sv */
// Read-only status register bank for the right motor and neighbours
`timescale 1ns/100ps
`default_nettype none
module mzs_status_bank (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Register read port
  input wire logic rd_en_i,
  input wire logic [15:0] rd_addr_i,
  output logic rd_valid_o,
  output logic [15:0] rd_data_o,
  output logic rd_err_o,
  // Register write port, always refused
  input wire logic wr_en_i,
  input wire logic [15:0] wr_addr_i,
  input wire logic [15:0] wr_data_i,
  output logic wr_refused_o,
  // Right motor measurements
  input wire logic [15:0] r_current_ma_i,
  input wire logic [15:0] r_freq_hz_i,
  input wire logic [7:0] r_motor_temp_i,
  input wire logic [7:0] r_board_temp_i,
  input wire logic r_running_i,
  input wire logic r_dir_ccw_i,
  input wire logic r_free_brake_i,
  input wire logic r_digital_mode_i,
  input wire logic [mzs_pkg::FAULT_W-1:0] r_faults_i,
  input wire logic r_sensor_err_i,
  input wire logic r_not_used_i,
  // Port digital I/O faults, index 0 left, 1 right
  input wire logic [1:0] dio_short_i,
  input wire logic [1:0] dio_overcur_i,
  // Servo, index 0 left, 1 right
  input wire logic [1:0][15:0] servo_pos_i,
  input wire logic [1:0] servo_done_i,
  input wire logic [1:0] servo_cmd_b0_i,
  input wire logic [1:0] servo_cmd_b1_i,
  // Neighbour links
  input wire logic nbr_keep_i,
  input wire logic up_wr_i,
  input wire logic [15:0] up_word_i,
  input wire logic dn_wr_i,
  input wire logic [15:0] dn_word_i,
  input wire logic trk_wr_i,
  input wire logic [15:0] trk1_i,
  input wire logic [15:0] trk2_i
);
  import mzs_pkg::*;

  mzs_word_t cur_r;
  mzs_word_t freq_r;
  mzs_word_t temp_r;
  mzs_word_t stat_r;
  mzs_word_t stat_nxt;
  mzs_word_t dio_r [2];
  mzs_word_t spos_r [2];
  mzs_word_t sstat_r [2];
  logic [1:0] rot;
  mzs_word_t rd_nxt;
  logic hit;
  logic unused_wr;

  mzs_nbr_if nb ();

  // Rotation state from run, direction and brake mode
  function automatic logic [1:0] rot_enc(input logic run, input logic ccw,
                                         input logic free);
    if (run) begin
      rot_enc = ccw ? ROT_CCW : ROT_CW;
    end else begin
      rot_enc = free ? ROT_FREE : ROT_STOP;
    end
  endfunction

  // Port I/O status word from the two fault flags
  function automatic mzs_word_t dio_word(input logic sc, input logic oc);
    dio_word = WORD_RST;
    dio_word[DIO_SHORT] = sc;
    dio_word[DIO_OVERCUR] = oc;
  endfunction

  // Neighbour link hand-off to the capture unit
  assign nb.keep = nbr_keep_i;
  assign nb.up_wr = up_wr_i;
  assign nb.up_word = up_word_i;
  assign nb.dn_wr = dn_wr_i;
  assign nb.dn_word = dn_word_i;
  assign nb.trk_wr = trk_wr_i;
  assign nb.trk1 = trk1_i;
  assign nb.trk2 = trk2_i;

  mzs_nbr_capture u_nbr (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .nb(nb.cap)
  );

  // Right motor measurement snapshot
  // current, frequency, temperatures
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cur_r <= WORD_RST;
      freq_r <= WORD_RST;
      temp_r <= WORD_RST;
    end else begin
      cur_r <= r_current_ma_i;
      freq_r <= r_freq_hz_i;
      temp_r <= {r_motor_temp_i, r_board_temp_i};
    end
  end

  // Motor status word assembly
  // rotation pair in low bits
  assign rot = rot_enc(r_running_i, r_dir_ccw_i, r_free_brake_i);
  // fault and mode flags, 3 and 4 zero
  always_comb begin
    stat_nxt = WORD_RST;
    stat_nxt[STAT_ROT_LSB +: 2] = rot;
    stat_nxt[STAT_DIGITAL] = r_digital_mode_i;
    stat_nxt[STAT_FAULT_LSB +: FAULT_W] = r_faults_i;
    stat_nxt[STAT_SENSOR_ERR] = r_sensor_err_i;
    stat_nxt[STAT_NOT_USED] = r_not_used_i;
  end

  // Motor status register
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      stat_r <= WORD_RST;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // Per-port digital I/O and servo words
  // port and servo flags
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 2; i++) begin
        dio_r[i] <= WORD_RST;
        spos_r[i] <= WORD_RST;
        sstat_r[i] <= WORD_RST;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        dio_r[i] <= dio_word(dio_short_i[i], dio_overcur_i[i]);
        spos_r[i] <= servo_pos_i[i];
        sstat_r[i] <= {13'h0, servo_cmd_b1_i[i], servo_cmd_b0_i[i],
                       servo_done_i[i]};
      end
    end
  end

  // Address decode of the read port
  // reset protection word is not a status word
  always_comb begin
    hit = 1'b1;
    rd_nxt = WORD_RST;
    unique case (rd_addr_i)
      OFS_L_SERVO_STAT: rd_nxt = sstat_r[0];
      OFS_R_SERVO_STAT: rd_nxt = sstat_r[1];
      OFS_L_DIO_STAT: rd_nxt = dio_r[0];
      OFS_L_SERVO_POS: rd_nxt = spos_r[0];
      OFS_R_CURRENT: rd_nxt = cur_r;
      OFS_R_FREQ: rd_nxt = freq_r;
      OFS_R_TEMP: rd_nxt = temp_r;
      OFS_R_STATUS: rd_nxt = stat_r;
      OFS_R_DIO_STAT: rd_nxt = dio_r[1];
      OFS_R_SERVO_POS: rd_nxt = spos_r[1];
      OFS_UP_STATE: rd_nxt = nb.up_state;
      OFS_UP_TRK1: rd_nxt = nb.up_trk1;
      OFS_UP_TRK2: rd_nxt = nb.up_trk2;
      OFS_DN_STATE: rd_nxt = nb.dn_state;
      ASM_RESET_PROT: hit = 1'b0;
      default: hit = 1'b0;
    endcase
  end

  // Read answer one cycle after the request
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rd_valid_o <= 1'b0;
      rd_err_o <= 1'b0;
      rd_data_o <= WORD_RST;
    end else begin
      rd_valid_o <= rd_en_i;
      rd_err_o <= rd_en_i && !hit;
      if (rd_en_i) begin
        rd_data_o <= rd_nxt;
      end
    end
  end

  // Write refusal pulse; data never stored
  // writes leave words unchanged
  assign unused_wr = ^{wr_addr_i, wr_data_i};
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wr_refused_o <= 1'b0;
    end else begin
      wr_refused_o <= wr_en_i;
    end
  end

  // Current word follows the input one cycle later
  property p_current;
    @(posedge sys_clk_i) disable iff (rst_i)
      ##1 cur_r == $past(r_current_ma_i);
  endproperty
  a_current: assert property (p_current)
    else $error("current word does not follow measurement");

  // Frequency word follows the input
  property p_freq;
    @(posedge sys_clk_i) disable iff (rst_i)
      ##1 freq_r == $past(r_freq_hz_i);
  endproperty
  a_freq: assert property (p_freq)
    else $error("frequency word does not follow measurement");

  // Temperature byte placement
  property p_temp;
    @(posedge sys_clk_i) disable iff (rst_i)
      ##1 temp_r[15:8] == $past(r_motor_temp_i) &&
        temp_r[7:0] == $past(r_board_temp_i);
  endproperty
  a_temp: assert property (p_temp)
    else $error("temperature bytes misplaced");

  // Clockwise running gives code 10
  property p_rot_cw;
    @(posedge sys_clk_i) disable iff (rst_i)
      r_running_i && !r_dir_ccw_i |=> stat_r[1:0] == 2'h2;
  endproperty
  a_rot_cw: assert property (p_rot_cw)
    else $error("clockwise rotation code wrong");

  // Free braking while stopped gives code 11
  property p_rot_free;
    @(posedge sys_clk_i) disable iff (rst_i)
      !r_running_i && r_free_brake_i |=> stat_r[1:0] == 2'h3;
  endproperty
  a_rot_free: assert property (p_rot_free)
    else $error("free braking code wrong");

  // Reserved status bits stay zero and stall maps to bit 13
  property p_stat_bits;
    @(posedge sys_clk_i) disable iff (rst_i)
      ##1 stat_r[4:3] == 2'h0 && stat_r[13] == $past(r_faults_i[8]) &&
        stat_r[5] == $past(r_faults_i[0]);
  endproperty
  a_stat_bits: assert property (p_stat_bits)
    else $error("fault bit layout wrong");

  // Mode flags in bits 2, 14, 15
  property p_mode_bits;
    @(posedge sys_clk_i) disable iff (rst_i)
      ##1 stat_r[2] == $past(r_digital_mode_i) &&
        stat_r[14] == $past(r_sensor_err_i) &&
        stat_r[15] == $past(r_not_used_i);
  endproperty
  a_mode_bits: assert property (p_mode_bits)
    else $error("mode flag bits wrong");

  // Right port short and over-current bits reach the read data
  property p_dio_read;
    @(posedge sys_clk_i) disable iff (rst_i)
      dio_short_i[1] && dio_overcur_i[1] ##1
        rd_en_i && rd_addr_i == OFS_R_DIO_STAT |=>
        rd_data_o[12] && rd_data_o[14] && rd_valid_o;
  endproperty
  a_dio_read: assert property (p_dio_read)
    else $error("port fault bits not reported");

  // Over-current alone sets only bit 14
  property p_overcur;
    @(posedge sys_clk_i) disable iff (rst_i)
      dio_overcur_i[0] && !dio_short_i[0] |=>
        dio_r[0] == 16'h4000;
  endproperty
  a_overcur: assert property (p_overcur)
    else $error("over-current word wrong");

  // Servo status echoes command bits and completion
  property p_servo;
    @(posedge sys_clk_i) disable iff (rst_i)
      ##1 sstat_r[1][2:0] == {$past(servo_cmd_b1_i[1]),
        $past(servo_cmd_b0_i[1]), $past(servo_done_i[1])};
  endproperty
  a_servo: assert property (p_servo)
    else $error("servo status bits wrong");

  // Servo echo reaches the read port for the left motor
  property p_servo_echo;
    @(posedge sys_clk_i) disable iff (rst_i)
      servo_cmd_b0_i[0] && servo_cmd_b1_i[0] ##1
        rd_en_i && rd_addr_i == OFS_L_SERVO_STAT |=> rd_data_o[2:1] == 2'h3;
  endproperty
  a_servo_echo: assert property (p_servo_echo)
    else $error("servo echo not reported");

  // Servo position word is the signed value as given
  property p_pos;
    @(posedge sys_clk_i) disable iff (rst_i)
      ##1 spos_r[0] == $past(servo_pos_i[0]);
  endproperty
  a_pos: assert property (p_pos)
    else $error("servo position word wrong");

  // Reset protection word is answered as not a status word
  property p_resprot;
    @(posedge sys_clk_i) disable iff (rst_i)
      rd_en_i && rd_addr_i == ASM_RESET_PROT |=> rd_err_o && rd_valid_o;
  endproperty
  a_resprot: assert property (p_resprot)
    else $error("reset protection word read as status");

  // A write never disturbs the stored upstream or downstream state word
  property p_write_ignored;
    @(posedge sys_clk_i) disable iff (rst_i)
      wr_en_i && !up_wr_i && !dn_wr_i && !trk_wr_i |=>
        $stable(nb.up_state) && $stable(nb.dn_state) && wr_refused_o;
  endproperty
  a_write_ignored: assert property (p_write_ignored)
    else $error("write altered a status word");

  c_read_status: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    rd_en_i && rd_addr_i == OFS_R_STATUS);
  c_ccw: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    stat_r[1:0] == 2'h1);
  c_write: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_en_i);
endmodule
`default_nettype wire

/* mzs_plc_model.sv */
// Polling controller model that reads and writes the status bank
`timescale 1ns/100ps
`default_nettype none
module mzs_plc_model (
  input wire logic sys_clk_i,
  output logic rd_en_o,
  output logic [15:0] rd_addr_o,
  input wire logic rd_valid_i,
  input wire logic [15:0] rd_data_i,
  input wire logic rd_err_i,
  output logic wr_en_o,
  output logic [15:0] wr_addr_o,
  output logic [15:0] wr_data_o,
  input wire logic wr_refused_i
);
  // Idle bus at time zero
  initial begin
    rd_en_o = 1'b0;
    rd_addr_o = 16'hffff;
    wr_en_o = 1'b0;
    wr_addr_o = 16'hffff;
    wr_data_o = 16'hffff;
  end

  // One read; address scrambled once released
  task automatic read_word(input logic [15:0] a, output logic v,
                           output logic [15:0] d, output logic e);
    @(posedge sys_clk_i);
    rd_en_o <= 1'b1;
    rd_addr_o <= a;
    @(posedge sys_clk_i);
    rd_en_o <= 1'b0;
    rd_addr_o <= ~a;
    #1;
    v = rd_valid_i;
    d = rd_data_i;
    e = rd_err_i;
  endtask

  // One write attempt; returns the refusal flag
  task automatic write_word(input logic [15:0] a, input logic [15:0] d,
                            output logic rf);
    @(posedge sys_clk_i);
    wr_en_o <= 1'b1;
    wr_addr_o <= a;
    wr_data_o <= d;
    @(posedge sys_clk_i);
    wr_en_o <= 1'b0;
    wr_addr_o <= ~a;
    wr_data_o <= ~d;
    #1;
    rf = wr_refused_i;
  endtask
endmodule
`default_nettype wire

/* mzs_status_bank_test.sv */
// Self-checking testbench for the motor zone status bank
`timescale 1ns/100ps
`default_nettype none
module mzs_status_bank_test;
  import mzs_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic rd_en, rd_valid, rd_err, wr_en, wr_refused;
  logic [15:0] rd_addr, rd_data, wr_addr, wr_data;
  logic [15:0] r_cur, r_freq, up_word, dn_word, trk1, trk2;
  logic [7:0] m_temp, b_temp;
  logic run, ccw, free_brk, dig, sens, nused;
  logic [8:0] faults;
  logic [1:0] dshort, dover, sdone, sb0, sb1;
  logic [1:0][15:0] spos;
  logic keep, up_wr, dn_wr, trk_wr, rf;
  logic [3:0] jv;
  logic [2:0] kv;
  int failures = 0;
  int tests_run = 0;
  int cyc = 0;
  mzs_zone_t codes [5] = '{ZONE_CLEAR_STOP, ZONE_CLEAR_RUN, ZONE_BLOCK_RUN,
                           ZONE_BLOCK_STOP, ZONE_BUSY};
  logic [15:0] ofs [14] = '{OFS_L_SERVO_STAT, OFS_R_SERVO_STAT,
    OFS_L_DIO_STAT, OFS_L_SERVO_POS, OFS_R_CURRENT, OFS_R_FREQ, OFS_R_TEMP,
    OFS_R_STATUS, OFS_R_DIO_STAT, OFS_R_SERVO_POS, OFS_UP_STATE,
    OFS_UP_TRK1, OFS_UP_TRK2, OFS_DN_STATE};

  // 125 MHz clock
  always #4 sys_clk = ~sys_clk;

  mzs_status_bank uut (
    .sys_clk_i(sys_clk), .rst_i(rst),
    .rd_en_i(rd_en), .rd_addr_i(rd_addr), .rd_valid_o(rd_valid),
    .rd_data_o(rd_data), .rd_err_o(rd_err),
    .wr_en_i(wr_en), .wr_addr_i(wr_addr), .wr_data_i(wr_data),
    .wr_refused_o(wr_refused),
    .r_current_ma_i(r_cur), .r_freq_hz_i(r_freq),
    .r_motor_temp_i(m_temp), .r_board_temp_i(b_temp),
    .r_running_i(run), .r_dir_ccw_i(ccw), .r_free_brake_i(free_brk),
    .r_digital_mode_i(dig), .r_faults_i(faults), .r_sensor_err_i(sens),
    .r_not_used_i(nused), .dio_short_i(dshort), .dio_overcur_i(dover),
    .servo_pos_i(spos), .servo_done_i(sdone), .servo_cmd_b0_i(sb0),
    .servo_cmd_b1_i(sb1), .nbr_keep_i(keep),
    .up_wr_i(up_wr), .up_word_i(up_word), .dn_wr_i(dn_wr),
    .dn_word_i(dn_word), .trk_wr_i(trk_wr), .trk1_i(trk1), .trk2_i(trk2)
  );

  mzs_plc_model plc (
    .sys_clk_i(sys_clk), .rd_en_o(rd_en), .rd_addr_o(rd_addr),
    .rd_valid_i(rd_valid), .rd_data_i(rd_data), .rd_err_i(rd_err),
    .wr_en_o(wr_en), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
    .wr_refused_i(wr_refused)
  );

  // Verdict and end of run
  task print_verdict();
    $display("Checks run %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Read one word and compare data and error flag
  task automatic chk(input logic [15:0] a, input logic [15:0] exp,
                     input logic exp_err);
    logic v;
    logic e;
    logic [15:0] d;
    plc.read_word(a, v, d, e);
    tests_run++;
    if (v !== 1'b1 || e !== exp_err || d !== exp) begin
      failures++;
      $display("ERROR t=%0t addr %h data %h want %h", $time, a, d, exp);
    end
  endtask

  // Write attempt that must be refused
  task automatic wchk(input logic [15:0] a, input logic [15:0] d);
    plc.write_word(a, d, rf);
    tests_run++;
    if (rf !== 1'b1) begin
      failures++;
      $display("ERROR t=%0t write to %h not refused", $time, a);
    end
  endtask

  // One neighbour update pulse on all three strobes
  task automatic nbr(input logic [15:0] u, input logic [15:0] d,
                     input logic [15:0] t1, input logic [15:0] t2);
    @(posedge sys_clk);
    up_wr <= 1'b1;
    dn_wr <= 1'b1;
    trk_wr <= 1'b1;
    up_word <= u;
    dn_word <= d;
    trk1 <= t1;
    trk2 <= t2;
    @(posedge sys_clk);
    up_wr <= 1'b0;
    dn_wr <= 1'b0;
    trk_wr <= 1'b0;
    up_word <= ~u;
    dn_word <= ~d;
    trk1 <= ~t1;
    trk2 <= ~t2;
  endtask

  // Hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      $display("ERROR t=%0t run did not finish", $time);
      print_verdict();
    end
  end

  // Main sequence
  initial begin
    {r_cur, r_freq, m_temp, b_temp, run, ccw, free_brk, dig} = '0;
    {faults, sens, nused, dshort, dover, spos, sdone, sb0, sb1} = '0;
    {keep, up_wr, dn_wr, trk_wr, up_word, dn_word, trk1, trk2} = '0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (ofs[i]) chk(ofs[i], 16'h0000, 1'b0);
    // Right motor measurements
    @(posedge sys_clk);
    r_cur <= 16'h076c;
    r_freq <= 16'h012c;
    m_temp <= 8'h41;
    b_temp <= 8'h1e;
    chk(OFS_R_CURRENT, 16'h076c, 1'b0);
    chk(OFS_R_FREQ, 16'h012c, 1'b0);
    chk(OFS_R_TEMP, 16'h411e, 1'b0);
    // Rotation codes, walking fault bit and flag bits
    for (int j = 0; j < 9; j++) begin
      jv = 4'(j);
      @(posedge sys_clk);
      run <= jv[1] ^ jv[0];
      ccw <= (jv[1:0] == 2'h1);
      free_brk <= (jv[1:0] == 2'h3);
      dig <= jv[0];
      sens <= jv[1];
      nused <= jv[2];
      faults <= 9'h001 << j;
      chk(OFS_R_STATUS, {jv[2], jv[1], 9'h001 << j, 2'b00, jv[0], jv[1:0]},
          1'b0);
    end
    // Port digital I/O faults, both ports
    @(posedge sys_clk);
    dshort <= 2'b01;
    dover <= 2'b10;
    chk(OFS_L_DIO_STAT, 16'h1000, 1'b0);
    chk(OFS_R_DIO_STAT, 16'h4000, 1'b0);
    @(posedge sys_clk);
    dshort <= 2'b10;
    dover <= 2'b01;
    chk(OFS_L_DIO_STAT, 16'h4000, 1'b0);
    chk(OFS_R_DIO_STAT, 16'h1000, 1'b0);
    // Both faults together on both ports
    @(posedge sys_clk);
    dshort <= 2'b11;
    dover <= 2'b11;
    chk(OFS_R_DIO_STAT, 16'h5000, 1'b0);
    chk(OFS_L_DIO_STAT, 16'h5000, 1'b0);
    // Servo position and status bits
    @(posedge sys_clk);
    spos <= {16'h0064, 16'hfff6};
    chk(OFS_L_SERVO_POS, 16'hfff6, 1'b0);
    chk(OFS_R_SERVO_POS, 16'h0064, 1'b0);
    for (int k = 0; k < 8; k++) begin
      kv = 3'(k);
      @(posedge sys_clk);
      sdone <= {~kv[0], kv[0]};
      sb0 <= {~kv[1], kv[1]};
      sb1 <= {~kv[2], kv[2]};
      chk(OFS_L_SERVO_STAT, {13'h0, kv}, 1'b0);
      chk(OFS_R_SERVO_STAT, {13'h0, ~kv}, 1'b0);
    end
    // Neighbour codes in low and high byte, tracking words
    @(posedge sys_clk);
    keep <= 1'b1;
    for (int n = 0; n < 5; n++) begin
      nbr({8'h00, codes[n]}, {codes[n], 8'h00}, {codes[n], 8'h5a},
          {8'hc3, codes[n]});
      chk(OFS_UP_STATE, {8'h00, codes[n]}, 1'b0);
      chk(OFS_DN_STATE, {codes[n], 8'h00}, 1'b0);
      chk(OFS_UP_TRK1, {codes[n], 8'h5a}, 1'b0);
      chk(OFS_UP_TRK2, {8'hc3, codes[n]}, 1'b0);
    end
    // Illegal codes dropped, tracking still taken
    nbr(16'h0003, 16'h0101, 16'h1234, 16'h5678);
    chk(OFS_UP_STATE, 16'h0006, 1'b0);
    chk(OFS_DN_STATE, 16'h0600, 1'b0);
    chk(OFS_UP_TRK1, 16'h1234, 1'b0);
    chk(OFS_UP_TRK2, 16'h5678, 1'b0);
    // Cleared connections freeze neighbour words
    @(posedge sys_clk);
    keep <= 1'b0;
    nbr(16'h0001, 16'h0100, 16'h0f0f, 16'hf0f0);
    chk(OFS_UP_STATE, 16'h0006, 1'b0);
    chk(OFS_DN_STATE, 16'h0600, 1'b0);
    chk(OFS_UP_TRK1, 16'h1234, 1'b0);
    chk(OFS_UP_TRK2, 16'h5678, 1'b0);
    // Reserved word and an unmapped address
    chk(ASM_RESET_PROT, 16'h0000, 1'b1);
    chk(16'h0001, 16'h0000, 1'b1);
    // Writes refused and without effect
    wchk(OFS_R_CURRENT, 16'hffff);
    chk(OFS_R_CURRENT, 16'h076c, 1'b0);
    wchk(OFS_UP_STATE, 16'h0001);
    chk(OFS_UP_STATE, 16'h0006, 1'b0);
    print_verdict();
  end
endmodule
`default_nettype wire
